/* hdl/embw_consts.svh */
// Timing constants and bus widths for the external bus wait-state controller.
`ifndef EMBW_CONSTS_SVH
`define EMBW_CONSTS_SVH
`define EMBW_ADDR_W 16
`define EMBW_DATA_W 8
`define EMBW_OSC_PER_STATE 2
`define EMBW_AUTO_WAITS 2'h1
`define EMBW_PERIPH_WAITS 2'h2
`define EMBW_BASE_STATES 2'h2
`define EMBW_CS_W 6
`define EMBW_CS_PERIPH 5
`define EMBW_REDRIVE_CYCLES 2'h3
`endif

/* hdl/embw_pkg.sv */
// Types shared by the external bus wait-state controller.
`default_nettype none
package embw_pkg;
  // Phases of one external access; address, strobe and hold are each one machine state long.
  typedef enum logic [2:0] {
    EMBW_IDLE = 3'h0,
    EMBW_ADDR = 3'h1,
    EMBW_STRB = 3'h2,
    EMBW_WAIT = 3'h3,
    EMBW_HOLD = 3'h4
  } embw_state_t;
endpackage
`default_nettype wire

/* hdl/embw_state_clk.sv */
// Machine-state timer: divides the oscillator clock by two and drives the clock output.
`timescale 1ns/1ps
`default_nettype none
`include "embw_consts.svh"
module embw_state_clk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Phase outputs.
  output logic clk_out_q,
  output logic fall_tick,
  output logic rise_tick
);
  // A state spans two oscillator periods: low half then high half.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_out_q <= 1'b1;
    end else begin
      clk_out_q <= ~clk_out_q;
    end
  end

  // The output falls on the next edge when it is high now.
  assign fall_tick = clk_out_q;
  // The output rises on the next edge when it is low now.
  assign rise_tick = ~clk_out_q;
endmodule
`default_nettype wire

/* hdl/embw_bus_ctrl.sv */
// External memory bus controller with automatic and pin-driven wait states.
//
// Function
// - One auto wait unless inhibit bit set.
// - Peripheral region bit sets two wait states in total.
// - Access lengths are 3, 4 or 5 states.
// - Wait pin low stretches access indefinitely.
// - Wait pin ignored while auto waits remain.
// - Wait pin sampled on clock output rise.
// - Machine state equals two oscillator periods.
// - Each wait lengthens strobe by one state.
// - Address launched after clock output falls.
// - Strobe and select low after address valid.
// - Address held until strobes return high.
// - Read releases bus before strobe, late redrive.
// - Read data captured at strobe rise.
// - Write data set up and held past strobe.
`timescale 1ns/1ps
`default_nettype none
`include "embw_consts.svh"
module embw_bus_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wait-state configuration levels.
  input wire logic auto_wait_inhibit,
  input wire logic periph_region_extra_wait,
  // Core access request.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic req_periph,
  input wire logic [`EMBW_CS_W-1:0] req_cs,
  input wire logic [`EMBW_ADDR_W-1:0] req_addr,
  input wire logic [`EMBW_DATA_W-1:0] req_wdata,
  output logic req_ready_q,
  output logic rsp_valid_q,
  output logic [`EMBW_DATA_W-1:0] rsp_rdata_q,
  // External bus pins.
  output logic system_clock_output,
  output logic [`EMBW_ADDR_W-1:0] ext_addr_q,
  output logic ext_rnw_q,
  output logic opcode_fetch_flag_n_q,
  output logic ext_data_strobe_n_q,
  output logic chip_select_e_one_n_q,
  output logic chip_select_e_two_n_q,
  output logic chip_select_h_one_n_q,
  output logic chip_select_h_two_n_q,
  output logic chip_select_h_three_n_q,
  output logic periph_region_select_n_q,
  input wire logic [`EMBW_DATA_W-1:0] data_in,
  output logic [`EMBW_DATA_W-1:0] data_out_q,
  output logic data_oe_n_q,
  input wire logic ext_wait_n
);
  // Machine-state timing from the divider.
  logic clk_out_q;
  logic fall_tick;
  logic rise_tick;

  embw_state_clk u_state_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_out_q(clk_out_q),
    .fall_tick(fall_tick),
    .rise_tick(rise_tick)
  );

  assign system_clock_output = clk_out_q;

  // Access state and latched attributes.
  embw_pkg::embw_state_t state_q;
  embw_pkg::embw_state_t state_d;
  logic [1:0] auto_left_q;
  logic [1:0] auto_left_d;
  logic write_q;
  logic periph_q;
  logic [`EMBW_CS_W-1:0] cs_q;
  logic [`EMBW_DATA_W-1:0] wdata_q;
  logic [1:0] redrive_q;
  logic [`EMBW_CS_W-1:0] cs_n_q;

  // Programmed automatic waits for the pending request.
  wire [1:0] auto_for_req;
  wire [1:0] base_auto;
  assign base_auto = auto_wait_inhibit ? 2'h0 : `EMBW_AUTO_WAITS;
  assign auto_for_req = (req_periph && periph_region_extra_wait) ?
                        `EMBW_PERIPH_WAITS : base_auto;

  // Wait pin counts only at the rising clock edge of a strobe state.
  wire wait_seen;
  assign wait_seen = rise_tick && !ext_wait_n;
  // Wait pin level held from the last rising clock output edge of the strobe.
  logic wait_seen_q;
  // An access starts only from idle, on an edge where the clock output falls.
  wire start_acc;
  assign start_acc = (state_q == embw_pkg::EMBW_IDLE) && req_valid && fall_tick;

  // Next-state decode; every transition lands on a falling clock output.
  always_comb begin
    state_d = state_q;
    auto_left_d = auto_left_q;
    unique case (state_q)
      embw_pkg::EMBW_IDLE: begin
        if (start_acc) begin
          state_d = embw_pkg::EMBW_ADDR;
          auto_left_d = auto_for_req;
        end
      end
      embw_pkg::EMBW_ADDR: begin
        if (fall_tick) begin
          state_d = embw_pkg::EMBW_STRB;
        end
      end
      embw_pkg::EMBW_STRB, embw_pkg::EMBW_WAIT: begin
        if (fall_tick) begin
          if (auto_left_q != 2'h0) begin
            auto_left_d = auto_left_q - 2'h1;
            state_d = embw_pkg::EMBW_WAIT;
          end else if (wait_seen_q) begin
            state_d = embw_pkg::EMBW_WAIT;
          end else begin
            state_d = embw_pkg::EMBW_HOLD;
          end
        end
      end
      embw_pkg::EMBW_HOLD: begin
        if (fall_tick) begin
          state_d = embw_pkg::EMBW_IDLE;
        end
      end
      default: begin
        state_d = embw_pkg::EMBW_IDLE;
      end
    endcase
  end

  // State register and automatic wait counter.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= embw_pkg::EMBW_IDLE;
      auto_left_q <= 2'h0;
    end else begin
      state_q <= state_d;
      auto_left_q <= auto_left_d;
    end
  end

  // Wait pin latch; ignored while automatic waits remain.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_seen_q <= 1'b0;
    end else if (fall_tick) begin
      wait_seen_q <= 1'b0;
    end else if (rise_tick && (state_q == embw_pkg::EMBW_STRB ||
                               state_q == embw_pkg::EMBW_WAIT)) begin
      wait_seen_q <= wait_seen && (auto_left_q == 2'h0);
    end
  end

  // Address, direction and fetch flag launch at access start and hold.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_addr_q <= {`EMBW_ADDR_W{1'b0}};
      ext_rnw_q <= 1'b1;
      opcode_fetch_flag_n_q <= 1'b1;
      write_q <= 1'b0;
      periph_q <= 1'b0;
      cs_q <= {`EMBW_CS_W{1'b0}};
      wdata_q <= {`EMBW_DATA_W{1'b0}};
    end else if (start_acc) begin
      ext_addr_q <= req_addr;
      ext_rnw_q <= !req_write;
      opcode_fetch_flag_n_q <= !req_fetch;
      write_q <= req_write;
      periph_q <= req_periph;
      cs_q <= req_cs;
      wdata_q <= req_wdata;
    end
  end

  // Strobe and selects are low across strobe and wait states only.
  wire strobe_next;
  assign strobe_next = (state_d == embw_pkg::EMBW_STRB) ||
                       (state_d == embw_pkg::EMBW_WAIT);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_data_strobe_n_q <= 1'b1;
      cs_n_q <= {`EMBW_CS_W{1'b1}};
    end else begin
      ext_data_strobe_n_q <= !strobe_next;
      cs_n_q <= strobe_next ? ~cs_q : {`EMBW_CS_W{1'b1}};
    end
  end

  assign chip_select_e_one_n_q = cs_n_q[0];
  assign chip_select_e_two_n_q = cs_n_q[1];
  assign chip_select_h_one_n_q = cs_n_q[2];
  assign chip_select_h_two_n_q = cs_n_q[3];
  assign chip_select_h_three_n_q = cs_n_q[4];
  assign periph_region_select_n_q = cs_n_q[`EMBW_CS_PERIPH];

  // Data bus drive: reads float before the strobe and stay off three oscillator periods more.
  wire strobe_rising;
  assign strobe_rising = !ext_data_strobe_n_q && !strobe_next;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_oe_n_q <= 1'b1;
      data_out_q <= {`EMBW_DATA_W{1'b0}};
      redrive_q <= 2'h0;
    end else begin
      if (start_acc) begin
        data_oe_n_q <= req_write ? 1'b0 : 1'b1;
        data_out_q <= req_write ? req_wdata : {`EMBW_DATA_W{1'b0}};
      end else if (write_q && state_q == embw_pkg::EMBW_HOLD && fall_tick) begin
        data_oe_n_q <= 1'b1;
      end
      if (strobe_rising && !write_q) begin
        redrive_q <= `EMBW_REDRIVE_CYCLES;
      end else if (redrive_q != 2'h0) begin
        redrive_q <= redrive_q - 2'h1;
      end
    end
  end

  // Read data captured as the strobe returns high.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= {`EMBW_DATA_W{1'b0}};
    end else begin
      rsp_valid_q <= strobe_rising;
      if (strobe_rising && !write_q) begin
        rsp_rdata_q <= data_in;
      end
    end
  end

  // Ready for a new request once idle and any read turnaround is over.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= (state_d == embw_pkg::EMBW_IDLE) && (redrive_q == 2'h0) && !start_acc;
    end
  end
endmodule
`default_nettype wire

/* test/embw_bus_sva.sv */
// Pin-level assertions for the external bus controller.
`timescale 1ns/1ps
`default_nettype none
`include "embw_consts.svh"
module embw_bus_sva (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched pins.
  input wire logic rsp_valid_q,
  input wire logic system_clock_output,
  input wire logic [`EMBW_ADDR_W-1:0] ext_addr_q,
  input wire logic ext_rnw_q,
  input wire logic ext_data_strobe_n_q,
  input wire logic periph_region_select_n_q,
  input wire logic data_oe_n_q,
  input wire logic ext_wait_n
);
  // All checks run on the oscillator clock and are muted in reset.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  clk_toggle_a:
    assert property ($past(rst_n) && $past(rst_n, 2) |->
                     system_clock_output != $past(system_clock_output))
    else $error("clock output missed a toggle");
  addr_edge_a:
    assert property ($changed(ext_addr_q) || $changed(ext_rnw_q) |-> $fell(system_clock_output))
    else $error("address moved away from a clock output fall");
  addr_hold_a:
    assert property (!ext_data_strobe_n_q || $rose(ext_data_strobe_n_q) |-> $stable(ext_addr_q))
    else $error("address moved while strobe active");
  sel_strobe_a:
    assert property (!periph_region_select_n_q |-> !ext_data_strobe_n_q)
    else $error("select active without strobe");
  rd_release_a:
    assert property (ext_rnw_q && (!ext_data_strobe_n_q || $rose(ext_data_strobe_n_q)) |->
                     data_oe_n_q)
    else $error("data bus driven during read");
  wr_drive_a:
    assert property (!ext_rnw_q && (!ext_data_strobe_n_q || $rose(ext_data_strobe_n_q)) |->
                     !data_oe_n_q)
    else $error("write data not driven");
  rsp_pulse_a:
    assert property ($rose(ext_data_strobe_n_q) |-> rsp_valid_q ##1 !rsp_valid_q)
    else $error("response pulse wrong");
  wait_gate_a:
    assert property ($rose(ext_data_strobe_n_q) |-> $past(ext_wait_n, 2) && !system_clock_output)
    else $error("strobe ended despite wait");
  // Main scenarios reached.
  rd_cov: cover property ($rose(ext_data_strobe_n_q) && ext_rnw_q);
  wr_cov: cover property ($rose(ext_data_strobe_n_q) && !ext_rnw_q);
  wait_cov: cover property (!ext_data_strobe_n_q && !ext_wait_n);
endmodule
bind embw_bus_ctrl embw_bus_sva u_sva (.sys_clk, .rst_n, .rsp_valid_q, .system_clock_output,
  .ext_addr_q, .ext_rnw_q, .ext_data_strobe_n_q, .periph_region_select_n_q, .data_oe_n_q,
  .ext_wait_n);
`default_nettype wire

/* test/embw_mem_model.sv */
// Memory model on the far side of the bus, with a stretchable wait line.
`timescale 1ns/1ps
`default_nettype none
module embw_mem_model (
  // Bus pins seen from the memory.
  input wire logic sys_clk,
  input wire logic clk_out,
  input wire logic strb_n,
  input wire logic rnw,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] wait_len,
  output logic [7:0] rdata,
  output logic wait_n
);
  logic [7:0] mem_q [16];
  logic [7:0] last_q;
  logic [3:0] cnt_q;
  // Read data holds through the strobe; a released bus shows a flipping value.
  assign rdata = (!strb_n && rnw) ? mem_q[addr[3:0]] : ~last_q;
  // Wait stays low for the first wait_len clock output rises in the strobe.
  assign wait_n = strb_n || (cnt_q >= wait_len);
  // Counts sampling edges and stores write data.
  always_ff @(posedge sys_clk) begin
    last_q <= rdata;
    cnt_q <= strb_n ? 4'h0 : cnt_q + {3'h0, !clk_out};
    if (!strb_n && !rnw) begin
      mem_q[addr[3:0]] <= wdata;
    end
  end
endmodule
`default_nettype wire

/* test/embw_bus_ctrl_test.sv */
// Testbench for the external bus wait-state controller.
`timescale 1ns/1ps
`default_nettype none
module embw_bus_ctrl_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic inh = 1'b0;
  logic pw = 1'b0;
  logic rv = 1'b0;
  logic rw = 1'b0;
  logic rf = 1'b0;
  logic rp = 1'b0;
  logic [5:0] cs = 6'h00;
  logic [15:0] ra = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [3:0] wl = 4'h0;
  logic rdy, rspv, clko, rnw, ofn, strb, oe, wt;
  logic [5:0] sel_n;
  logic [7:0] rdat, din, dout;
  logic [15:0] addr;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  embw_bus_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .auto_wait_inhibit(inh),
    .periph_region_extra_wait(pw), .req_valid(rv), .req_write(rw), .req_fetch(rf),
    .req_periph(rp), .req_cs(cs), .req_addr(ra), .req_wdata(wd), .req_ready_q(rdy),
    .rsp_valid_q(rspv), .rsp_rdata_q(rdat), .system_clock_output(clko), .ext_addr_q(addr),
    .ext_rnw_q(rnw), .opcode_fetch_flag_n_q(ofn), .ext_data_strobe_n_q(strb),
    .chip_select_e_one_n_q(sel_n[0]), .chip_select_e_two_n_q(sel_n[1]),
    .chip_select_h_one_n_q(sel_n[2]), .chip_select_h_two_n_q(sel_n[3]),
    .chip_select_h_three_n_q(sel_n[4]), .periph_region_select_n_q(sel_n[5]),
    .data_in(din), .data_out_q(dout), .data_oe_n_q(oe), .ext_wait_n(wt));
  embw_mem_model mem (.sys_clk(sys_clk), .clk_out(clko), .strb_n(strb), .rnw(rnw),
    .addr(addr), .wdata(dout), .wait_len(wl), .rdata(din), .wait_n(wt));
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // One access; on reads d is the expected data, k the wait pin stretch.
  task automatic acc(input logic w, input logic p, input logic [5:0] c, input logic [15:0] a,
      input logic [7:0] d, input logic [3:0] k);
    int n;
    int t;
    int st;
    n = 0;
    t = 0;
    st = (p && pw) ? 3 : (inh ? 1 : 2);
    if (int'(k) + 1 > st)
      st = int'(k) + 1;
    while (rdy !== 1'b1 && t < 99) begin
      @(negedge sys_clk);
      t++;
    end
    {rv, rw, rp, cs, ra, wd, wl} = {1'b1, w, p, c, a, d, k};
    while (rdy !== 1'b0 && t < 99) begin
      @(negedge sys_clk);
      t++;
    end
    rv = 1'b0;
    while (rspv !== 1'b1 && t < 99) begin
      if (strb === 1'b0) begin
        n++;
        chk("select", {26'h0, ~c}, {26'h0, sel_n});
        chk("address", {16'h0, a}, {16'h0, addr});
        chk("fetch", {31'h0, ~rf}, {31'h0, ofn});
      end
      @(negedge sys_clk);
      t++;
    end
    chk("access limit", 32'h0, {31'h0, t >= 99});
    chk("strobe cycles", 2 * st, n);
    if (!w)
      chk("read data", {24'h0, d}, {24'h0, rdat});
  endtask
  // Every wait bit setting against both regions.
  task automatic t_table;
    for (int i = 0; i < 8; i++) begin
      {pw, inh} = i[1:0];
      acc(1'b1, i[2], i[2] ? 6'h20 : 6'h01, 16'h0010, 8'h5a, 4'h0);
    end
    $display("table done");
  endtask
  // Back-to-back writes and read-backs.
  task automatic t_rw;
    {pw, inh} = 2'h0;
    acc(1'b1, 1'b0, 6'h02, 16'h0003, 8'ha5, 4'h0);
    acc(1'b1, 1'b0, 6'h04, 16'h0104, 8'h3c, 4'h0);
    acc(1'b0, 1'b0, 6'h02, 16'h0003, 8'ha5, 4'h0);
    acc(1'b0, 1'b0, 6'h04, 16'h0104, 8'h3c, 4'h0);
    $display("read write done");
  endtask
  // Wait pin stretches beyond, and within, the automatic waits.
  task automatic t_wait;
    {pw, inh} = 2'h1;
    acc(1'b0, 1'b0, 6'h02, 16'h0003, 8'ha5, 4'h3);
    {pw, inh} = 2'h0;
    acc(1'b0, 1'b0, 6'h02, 16'h0003, 8'ha5, 4'h5);
    pw = 1'b1;
    acc(1'b1, 1'b1, 6'h20, 16'h0007, 8'h77, 4'h1);
    $display("wait done");
  endtask
  // Each chip select alone, fetch flag alternating.
  task automatic t_sel;
    for (int j = 0; j < 6; j++) begin
      rf = j[0];
      acc(1'b1, j == 5, 6'h01 << j, 16'h0008, 8'h11, 4'h0);
    end
    $display("select done");
  endtask
  // Prints the counts and the verdict, then stops.
  task final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    t_table;
    t_rw;
    t_wait;
    t_sel;
    final_report;
  end
endmodule
`default_nettype wire
